// ### rtl/erkc_pkg.sv
/*
 * Constants, carrier types and preset lookups for the command executor
 * that covers memory-to-register loads, protocol presets, key fetch and
 * store, random fill and soft re-initialisation.
 * Assumes one system clock; the FIFO, the nonvolatile memory, the
 * register set, the crypto key buffer and the random source are outside.
 */
// Behaviour
// [RULE_01] register load is 0ch; params: address low, high, index, count
// [RULE_02] register load copies count memory bytes into consecutive registers
// [RULE_03] register load aborts on short FIFO or memory address out of range
// [RULE_04] preset load is 0dh; params: receive number, then transmit number
// [RULE_05] preset load copies receive, transmit areas; aborts on short FIFO
// [RULE_06] receive presets 00 to 17: type A, B, Manchester, vicinity, 18000-3
// [RULE_07] tx presets: Miller, NRZ, Manchester, PPM, UID, PIE; 18 reserved
// [RULE_08] key fetch is 0eh, one slot; key to crypto unit, slot checked
// [RULE_09] key store is 0fh; first slot index then six bytes per key
// [RULE_10] key store writes slot n, then n+1 and onward until FIFO empties
// [RULE_11] a trailing key of fewer than 6 bytes is left unstored in the FIFO
// [RULE_12] key store aborts on short FIFO or first slot outside key area
// [RULE_13] random fill is 1ch; pushes random bytes until the FIFO is full
// [RULE_14] soft reinit is 1fh; copies every register default from memory
// [RULE_15] command register is host written and returns to idle on completion
// [RULE_16] writing idle code 00h ends whatever command runs
// [RULE_17] parameters and results pass through FIFO data register at 05h
// [RULE_18] an abort stops without further writes and returns command to idle
package erkc_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_IDLE = 8'h00;
	localparam logic [7:0] CMD_REG_LOAD = 8'h0c;
	localparam logic [7:0] CMD_PROTO = 8'h0d;
	localparam logic [7:0] CMD_KEY_FETCH = 8'h0e;
	localparam logic [7:0] CMD_KEY_STORE = 8'h0f;
	localparam logic [7:0] CMD_RANDOM = 8'h1c;
	localparam logic [7:0] CMD_SOFT = 8'h1f;
	localparam logic [7:0] FIFO_DATA_ADDR = 8'h05; // RULE_17

	// ----------------------------------------------------------------
	// parameter counts and memory layout
	// ----------------------------------------------------------------
	localparam logic [8:0] NEED_REG_LOAD = 9'h004;
	localparam logic [8:0] NEED_PROTO = 9'h002;
	localparam logic [8:0] NEED_ONE = 9'h001;
	localparam logic [8:0] NEED_KEY_STORE = 9'h007;
	localparam logic [8:0] KEY_BYTES = 9'h006;
	localparam logic [2:0] KEY_LAST = 3'h5;
	localparam logic [12:0] LOAD_ADDR_MIN = 13'h0080;
	localparam logic [12:0] LOAD_ADDR_MAX = 13'h00ff;
	localparam logic [12:0] KEY_BASE = 13'h0c00;
	localparam logic [12:0] RX_BASE = 13'h0200;
	localparam logic [12:0] TX_BASE = 13'h0400;
	localparam logic [12:0] DEF_BASE = 13'h0000;
	localparam logic [7:0] KEY_SLOTS = 8'h80;
	localparam logic [7:0] RX_LEN = 8'h08;
	localparam logic [7:0] TX_LEN = 8'h08;
	localparam logic [7:0] RX_REG = 8'h48;
	localparam logic [7:0] TX_REG = 8'h28;
	localparam logic [7:0] REG_COUNT = 8'h80;
	localparam logic [7:0] PROTO_LAST = 8'h11;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic req;
		logic we;
		logic [12:0] addr;
		logic [7:0] wdata;
	} erkc_nvm_req_t;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} erkc_reg_wr_t;

	typedef struct packed {
		logic we;
		logic [2:0] idx;
		logic [7:0] data;
	} erkc_key_wr_t;

	typedef struct packed {
		logic [8:0] level;
		logic full;
		logic [7:0] rdata;
	} erkc_fifo_st_t;

	typedef enum logic [2:0] {
		RXC_MAN_SUBC = 3'h0, RXC_BPSK = 3'h1, RXC_MAN = 3'h2,
		RXC_SSC = 3'h3, RXC_DSC = 3'h4, RXC_EPC3 = 3'h5
	} erkc_rx_coding_t;

	typedef enum logic [2:0] {
		TXC_MILLER = 3'h0, TXC_NRZ = 3'h1, TXC_MAN = 3'h2,
		TXC_PPM4 = 3'h3, TXC_PPM256 = 3'h4, TXC_UID = 3'h5,
		TXC_PIE = 3'h6
	} erkc_tx_coding_t;

	// ----------------------------------------------------------------
	// preset number to coding
	// ----------------------------------------------------------------
	function automatic erkc_rx_coding_t erkc_rx_class(logic [7:0] n);
		if (n == 8'h00) return RXC_MAN_SUBC; // RULE_06
		if (n <= 8'h07) return RXC_BPSK;
		if (n <= 8'h09) return RXC_MAN;
		if (n == 8'h0c) return RXC_DSC;
		if (n <= 8'h0d) return RXC_SSC;
		return RXC_EPC3;
	endfunction : erkc_rx_class

	function automatic erkc_tx_coding_t erkc_tx_class(logic [7:0] n);
		if (n <= 8'h03) return TXC_MILLER; // RULE_07
		if (n <= 8'h07) return TXC_NRZ;
		if (n <= 8'h09) return TXC_MAN;
		if (n <= 8'h0b) return TXC_PPM4;
		if (n == 8'h0c) return TXC_PPM256;
		if (n == 8'h0d) return TXC_UID;
		return TXC_PIE;
	endfunction : erkc_tx_class

endpackage : erkc_pkg

// ### rtl/erkc_nvm_port.sv
/*
 * One-access-at-a-time port to the nonvolatile memory.
 * Assumes the memory answers a held request with a one-cycle ack and,
 * for reads, valid data in the same cycle as the ack.
 */
`timescale 1ns/1ps
module erkc_nvm_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic we,
	input wire logic [12:0] addr,
	input wire logic [7:0] wdata,
	input wire logic nvm_ack,
	input wire logic [7:0] nvm_rdata,
	output erkc_pkg::erkc_nvm_req_t nvm_q,
	output logic done_q,
	output logic [7:0] rdata_q
);
	import erkc_pkg::*;

	// a request stays up until acked, even if the command was dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			nvm_q <= '0;
			done_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			if (nvm_q.req) begin
				if (nvm_ack) begin
					nvm_q.req <= 1'b0;
					done_q <= 1'b1;
					rdata_q <= nvm_rdata;
				end
			end else if (go) begin
				nvm_q <= '{req: 1'b1, we: we, addr: addr, wdata: wdata};
			end
		end
	end

endmodule : erkc_nvm_port

// ### rtl/erkc_exec.sv
/*
 * Command executor: register load, protocol preset load, key fetch,
 * key store, random fill and soft re-initialisation.
 * Assumes the FIFO shows its head byte, level and full flag on the same
 * clock and acts on a one-cycle pop or push pulse at the next edge.
 */
`timescale 1ns/1ps
module erkc_exec (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_q,
	input erkc_pkg::erkc_fifo_st_t fifo_st,
	output logic fifo_rd_q,
	output logic fifo_wr_q,
	output logic [7:0] fifo_wdata_q,
	input wire logic rng_valid,
	input wire logic [7:0] rng_data,
	output erkc_pkg::erkc_nvm_req_t nvm_q,
	input wire logic nvm_ack,
	input wire logic [7:0] nvm_rdata,
	output erkc_pkg::erkc_reg_wr_t reg_wr_q,
	output erkc_pkg::erkc_key_wr_t key_wr_q,
	output erkc_pkg::erkc_rx_coding_t rx_coding_q,
	output erkc_pkg::erkc_tx_coding_t tx_coding_q,
	output logic done_q,
	output logic abort_q
);
	import erkc_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_CHECK = 4'h1, S_GET = 4'h3, S_GETW = 4'h2,
		S_SETUP = 4'h6, S_COPY = 4'h7, S_COPYW = 4'h5, S_KPOP = 4'h4,
		S_KNVM = 4'hc, S_KWAIT = 4'hd, S_RND = 4'hf, S_RNDW = 4'he
	} erkc_state_t;

	erkc_state_t state_q;
	logic [7:0] cur_q;
	logic [7:0] par_q [4];
	logic [2:0] idx_q;
	logic phase_q;
	logic [12:0] src_q;
	logic [7:0] dst_q;
	logic [7:0] cnt_q;
	logic [7:0] slot_q;
	logic [2:0] kb_q;
	logic [7:0] kbyte_q;
	logic go_q;
	logic go_we_q;
	logic [12:0] go_addr_q;
	logic [7:0] go_wdata_q;
	logic nvm_done;
	logic [7:0] nvm_rd;
	logic [12:0] load_addr;

	// ----------------------------------------------------------------
	// per-command parameter needs
	// ----------------------------------------------------------------
	function automatic logic ours(logic [7:0] c);
		return c == CMD_REG_LOAD || c == CMD_PROTO || c == CMD_KEY_FETCH ||
			c == CMD_KEY_STORE || c == CMD_RANDOM || c == CMD_SOFT;
	endfunction : ours

	function automatic logic [8:0] need_lvl(logic [7:0] c);
		unique case (c)
			CMD_REG_LOAD: return NEED_REG_LOAD;
			CMD_PROTO: return NEED_PROTO;
			CMD_KEY_FETCH: return NEED_ONE;
			CMD_KEY_STORE: return NEED_KEY_STORE;
			default: return 9'h000;
		endcase
	endfunction : need_lvl

	function automatic logic [2:0] need_pop(logic [7:0] c);
		unique case (c)
			CMD_REG_LOAD: return NEED_REG_LOAD[2:0];
			CMD_PROTO: return NEED_PROTO[2:0];
			CMD_KEY_FETCH, CMD_KEY_STORE: return NEED_ONE[2:0];
			default: return 3'h0;
		endcase
	endfunction : need_pop

	assign load_addr = {par_q[1][4:0], par_q[0]};

	erkc_nvm_port u_port (
		.mclk(mclk),
		.rst_n(rst_n),
		.go(go_q),
		.we(go_we_q),
		.addr(go_addr_q),
		.wdata(go_wdata_q),
		.nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata),
		.nvm_q(nvm_q),
		.done_q(nvm_done),
		.rdata_q(nvm_rd)
	);

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cmd_q <= CMD_IDLE;
		else if (cmd_wr)
			cmd_q <= cmd_wdata; // RULE_15 RULE_16
		else if (done_q || abort_q)
			cmd_q <= CMD_IDLE; // RULE_15 RULE_18
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			cur_q <= CMD_IDLE;
			par_q <= '{default: 8'h00};
			idx_q <= 3'h0;
			phase_q <= 1'b0;
			src_q <= 13'h0000;
			dst_q <= 8'h00;
			cnt_q <= 8'h00;
			slot_q <= 8'h00;
			kb_q <= 3'h0;
			kbyte_q <= 8'h00;
			go_q <= 1'b0;
			go_we_q <= 1'b0;
			go_addr_q <= 13'h0000;
			go_wdata_q <= 8'h00;
			fifo_rd_q <= 1'b0;
			fifo_wr_q <= 1'b0;
			fifo_wdata_q <= 8'h00;
			reg_wr_q <= '0;
			key_wr_q <= '0;
			rx_coding_q <= RXC_MAN_SUBC;
			tx_coding_q <= TXC_MILLER;
			done_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			go_q <= 1'b0;
			fifo_rd_q <= 1'b0;
			fifo_wr_q <= 1'b0;
			reg_wr_q.we <= 1'b0;
			key_wr_q.we <= 1'b0;
			done_q <= 1'b0;
			abort_q <= 1'b0;
			if (cmd_wr) begin
				// any host write, idle included, ends the running command
				state_q <= ours(cmd_wdata) ? S_CHECK : S_IDLE; // RULE_16
				cur_q <= cmd_wdata;
				idx_q <= 3'h0;
				phase_q <= 1'b0;
				kb_q <= 3'h0;
			end else begin
				unique case (state_q)
				S_IDLE: begin
				end
				S_CHECK: if (!nvm_q.req) begin
					if (fifo_st.level < need_lvl(cur_q)) begin
						abort_q <= 1'b1; // RULE_03 RULE_05 RULE_08 RULE_12
						state_q <= S_IDLE;
					end else if (need_pop(cur_q) == 3'h0) begin
						state_q <= S_SETUP;
					end else begin
						state_q <= S_GET;
					end
				end
				S_GET: begin
					par_q[idx_q[1:0]] <= fifo_st.rdata; // RULE_01 RULE_04 RULE_17
					fifo_rd_q <= 1'b1;
					state_q <= S_GETW;
				end
				S_GETW: begin
					idx_q <= idx_q + 3'h1;
					state_q <= (idx_q + 3'h1 == need_pop(cur_q)) ? S_SETUP : S_GET;
				end
				S_SETUP: begin
					state_q <= S_COPY;
					unique case (cur_q)
					CMD_REG_LOAD: begin
						src_q <= load_addr; // RULE_02
						dst_q <= par_q[2];
						cnt_q <= par_q[3];
						if (par_q[1][7:5] != 3'h0 || load_addr < LOAD_ADDR_MIN ||
							load_addr > LOAD_ADDR_MAX) begin
							abort_q <= 1'b1; // RULE_03
							state_q <= S_IDLE;
						end
					end
					CMD_PROTO: begin
						src_q <= RX_BASE + 13'(par_q[0]) * 13'(RX_LEN); // RULE_05
						dst_q <= RX_REG;
						cnt_q <= RX_LEN;
						if (par_q[0] > PROTO_LAST || par_q[1] > PROTO_LAST) begin
							abort_q <= 1'b1; // RULE_07
							state_q <= S_IDLE;
						end else begin
							rx_coding_q <= erkc_rx_class(par_q[0]); // RULE_06
							tx_coding_q <= erkc_tx_class(par_q[1]); // RULE_07
						end
					end
					CMD_KEY_FETCH: begin
						src_q <= KEY_BASE + 13'(par_q[0]) * 13'(KEY_BYTES); // RULE_08
						dst_q <= 8'h00;
						cnt_q <= KEY_BYTES[7:0];
						if (par_q[0] >= KEY_SLOTS) begin
							abort_q <= 1'b1; // RULE_08
							state_q <= S_IDLE;
						end
					end
					CMD_KEY_STORE: begin
						slot_q <= par_q[0]; // RULE_09
						if (par_q[0] >= KEY_SLOTS) begin
							abort_q <= 1'b1; // RULE_12
							state_q <= S_IDLE;
						end else begin
							state_q <= S_KPOP;
						end
					end
					CMD_RANDOM: state_q <= S_RND;
					default: begin
						src_q <= DEF_BASE; // RULE_14
						dst_q <= 8'h00;
						cnt_q <= REG_COUNT;
					end
					endcase
				end
				S_COPY: begin
					if (cnt_q == 8'h00) begin
						if (cur_q == CMD_PROTO && !phase_q) begin
							phase_q <= 1'b1; // RULE_05
							src_q <= TX_BASE + 13'(par_q[1]) * 13'(TX_LEN);
							dst_q <= TX_REG;
							cnt_q <= TX_LEN;
						end else begin
							done_q <= 1'b1; // RULE_15
							state_q <= S_IDLE;
						end
					end else begin
						go_q <= 1'b1;
						go_we_q <= 1'b0;
						go_addr_q <= src_q;
						state_q <= S_COPYW;
					end
				end
				S_COPYW: if (nvm_done) begin
					if (cur_q == CMD_KEY_FETCH)
						key_wr_q <= '{we: 1'b1, idx: dst_q[2:0], data: nvm_rd};
					else
						reg_wr_q <= '{we: 1'b1, addr: dst_q, data: nvm_rd}; // RULE_02 RULE_14
					src_q <= src_q + 13'h0001;
					dst_q <= dst_q + 8'h01;
					cnt_q <= cnt_q - 8'h01;
					state_q <= S_COPY;
				end
				S_KPOP: begin
					// a key is only started with all six bytes present
					if (kb_q == 3'h0 && (fifo_st.level < KEY_BYTES ||
						slot_q >= KEY_SLOTS)) begin
						done_q <= 1'b1; // RULE_10 RULE_11
						state_q <= S_IDLE;
					end else begin
						kbyte_q <= fifo_st.rdata;
						fifo_rd_q <= 1'b1;
						state_q <= S_KNVM;
					end
				end
				S_KNVM: begin
					go_q <= 1'b1;
					go_we_q <= 1'b1;
					go_addr_q <= KEY_BASE + 13'(slot_q) * 13'(KEY_BYTES) +
						13'(kb_q); // RULE_10
					go_wdata_q <= kbyte_q;
					state_q <= S_KWAIT;
				end
				S_KWAIT: if (nvm_done) begin
					if (kb_q == KEY_LAST) begin
						kb_q <= 3'h0;
						slot_q <= slot_q + 8'h01; // RULE_10
					end else begin
						kb_q <= kb_q + 3'h1;
					end
					state_q <= S_KPOP;
				end
				S_RND: begin
					if (fifo_st.full) begin
						done_q <= 1'b1; // RULE_13
						state_q <= S_IDLE;
					end else if (rng_valid) begin
						fifo_wr_q <= 1'b1; // RULE_13
						fifo_wdata_q <= rng_data;
						state_q <= S_RNDW;
					end
				end
				S_RNDW: state_q <= S_RND;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_cmd_back_idle: assert property ((done_q || abort_q) && !cmd_wr |=> // RULE_15
		cmd_q == CMD_IDLE) else $error("command register not back to idle");
	a_idle_ends_cmd: assert property (cmd_wr && cmd_wdata == CMD_IDLE |=> // RULE_16
		state_q == S_IDLE ##1 !go_q && !fifo_rd_q && !fifo_wr_q)
		else $error("idle write did not end command");
	a_load_short_abort: assert property (state_q == S_CHECK && !cmd_wr && // RULE_03
		!nvm_q.req && cur_q == CMD_REG_LOAD && fifo_st.level < NEED_REG_LOAD
		|=> abort_q && !fifo_rd_q) else $error("short register load kept going");
	a_proto_short_abort: assert property (state_q == S_CHECK && !cmd_wr && // RULE_05
		!nvm_q.req && cur_q == CMD_PROTO && fifo_st.level < NEED_PROTO
		|=> abort_q) else $error("short preset load kept going");
	a_copy_reg_data: assert property (state_q == S_COPYW && nvm_done && // RULE_02
		!cmd_wr && cur_q != CMD_KEY_FETCH |=> reg_wr_q.we &&
		reg_wr_q.data == $past(nvm_rd) && reg_wr_q.addr == $past(dst_q))
		else $error("register copy wrote wrong byte");
	a_fetch_slot_range: assert property (state_q == S_SETUP && !cmd_wr && // RULE_08
		cur_q == CMD_KEY_FETCH && par_q[0] >= KEY_SLOTS |=> abort_q &&
		state_q == S_IDLE) else $error("key fetch slot not checked");
	a_store_slot_range: assert property (state_q == S_SETUP && !cmd_wr && // RULE_12
		cur_q == CMD_KEY_STORE && par_q[0] >= KEY_SLOTS |=> abort_q)
		else $error("key store slot not checked");
	a_partial_key_kept: assert property (state_q == S_KPOP && !cmd_wr && // RULE_11
		kb_q == 3'h0 && fifo_st.level < KEY_BYTES |=> !fifo_rd_q && done_q)
		else $error("partial key was popped");
	a_store_addr: assert property (state_q == S_KNVM && !cmd_wr |=> // RULE_10
		go_q && go_we_q && go_addr_q == KEY_BASE +
		13'($past(slot_q)) * 13'(KEY_BYTES) + 13'($past(kb_q)))
		else $error("key byte went to wrong address");
	a_rnd_until_full: assert property (state_q == S_RND && !cmd_wr && // RULE_13
		fifo_st.full |=> done_q && !fifo_wr_q) else $error("random fill overran");
	a_soft_setup: assert property (state_q == S_SETUP && !cmd_wr && // RULE_14
		cur_q == CMD_SOFT |=> state_q == S_COPY && src_q == DEF_BASE &&
		cnt_q == REG_COUNT) else $error("soft reinit setup wrong");

endmodule : erkc_exec

// ### testbench/erkc_far_model.sv
/*
 * Far-side model of the command executor: FIFO, nonvolatile memory with a
 * settable answer delay, and a random source that is ready every other cycle.
 * Assumes the bench loads FIFO bytes through fq between commands.
 */
`timescale 1ns/1ps
module erkc_far_model #(
	parameter int DEPTH = 64
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fifo_rd_q,
	input wire logic fifo_wr_q,
	input wire logic [7:0] fifo_wdata_q,
	output erkc_pkg::erkc_fifo_st_t fifo_st,
	input erkc_pkg::erkc_nvm_req_t nvm_q,
	output logic nvm_ack,
	output logic [7:0] nvm_rdata,
	output logic rng_valid,
	output logic [7:0] rng_data
);
	import erkc_pkg::*;
	logic [7:0] fq[$];
	int lat = 0;
	int cnt = 0;
	int ovf = 0;

	function automatic logic [7:0] memv(input logic [12:0] a);
		return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h3c;
	endfunction : memv

	// ----------------------------------------------------------------
	// fifo: host parameters and results pass through here
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (fifo_rd_q && fq.size() > 0)
			void'(fq.pop_front());
		if (fifo_wr_q && fq.size() >= DEPTH)
			ovf++;
		else if (fifo_wr_q)
			fq.push_back(fifo_wdata_q);
	end

	// status settles half a cycle after each change
	always @(negedge mclk) begin
		fifo_st.level <= 9'(fq.size());
		fifo_st.full <= (fq.size() >= DEPTH);
		fifo_st.rdata <= (fq.size() > 0) ? fq[0] : ~fifo_st.rdata;
	end

	// ----------------------------------------------------------------
	// memory: one access at a time, ack after lat waiting cycles
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		nvm_ack <= 1'b0;
		nvm_rdata <= ~nvm_rdata;
		if (!rst_n)
			cnt <= 0;
		else if (nvm_q.req && !nvm_ack) begin
			if (cnt >= lat) begin
				nvm_ack <= 1'b1;
				if (!nvm_q.we)
					nvm_rdata <= memv(nvm_q.addr);
				cnt <= 0;
			end else
				cnt <= cnt + 1;
		end
	end

	always @(posedge mclk) begin
		rng_valid <= ~rng_valid;
		rng_data <= rng_data + 8'h07;
	end

	initial begin
		fifo_st = '0;
		nvm_ack = 1'b0;
		nvm_rdata = 8'h5a;
		rng_valid = 1'b0;
		rng_data = 8'h11;
	end
endmodule : erkc_far_model

// ### testbench/tb_top.sv
/*
 * Self-checking bench for the command executor.
 * Assumes erkc_far_model stands for FIFO, memory and random source.
 */
`timescale 1ns/1ps
module tb_top;
	import erkc_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_wr = 1'b0;
	logic [7:0] cmd_wdata = 8'h00;
	logic [7:0] cmd_q;
	logic [7:0] fifo_wdata_q;
	logic [7:0] rng_data;
	logic [7:0] nvm_rdata;
	logic fifo_rd_q, fifo_wr_q, rng_valid, nvm_ack, done_q, abort_q;
	erkc_fifo_st_t fifo_st;
	erkc_nvm_req_t nvm_q;
	erkc_reg_wr_t reg_wr_q;
	erkc_key_wr_t key_wr_q;
	erkc_rx_coding_t rx_coding_q;
	erkc_tx_coding_t tx_coding_q;
	int errors = 0;
	int total_checks = 0;
	int nreg = 0, nkey = 0, nnvw = 0, ndone = 0;
	logic [12:0] src = '0, src2 = '0, kbase = '0;
	logic [7:0] dst = '0;
	logic sc2 = 1'b0;
	logic [7:0] rx_t [6] = '{8'h00, 8'h08, 8'h0c, 8'h11, 8'h05, 8'h0a};
	logic [7:0] tx_t [6] = '{8'h00, 8'h0d, 8'h0c, 8'h0a, 8'h06, 8'h11};
	logic [2:0] rc_t [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1, 3'h3};
	logic [2:0] tc_t [6] = '{3'h0, 3'h5, 3'h4, 3'h3, 3'h1, 3'h6};

	always #5 mclk = ~mclk;

	erkc_exec dut (.mclk(mclk), .rst_n(rst_n), .cmd_wr(cmd_wr),
		.cmd_wdata(cmd_wdata), .cmd_q(cmd_q), .fifo_st(fifo_st),
		.fifo_rd_q(fifo_rd_q), .fifo_wr_q(fifo_wr_q),
		.fifo_wdata_q(fifo_wdata_q), .rng_valid(rng_valid),
		.rng_data(rng_data), .nvm_q(nvm_q), .nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata), .reg_wr_q(reg_wr_q), .key_wr_q(key_wr_q),
		.rx_coding_q(rx_coding_q), .tx_coding_q(tx_coding_q),
		.done_q(done_q), .abort_q(abort_q));

	erkc_far_model m (.mclk(mclk), .rst_n(rst_n), .fifo_rd_q(fifo_rd_q),
		.fifo_wr_q(fifo_wr_q), .fifo_wdata_q(fifo_wdata_q),
		.fifo_st(fifo_st), .nvm_q(nvm_q), .nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata), .rng_valid(rng_valid), .rng_data(rng_data));

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task end_of_test;
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// write monitor
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (reg_wr_q.we && sc2 && reg_wr_q.addr < RX_REG)
			chk(16'(reg_wr_q.data), 16'(m.memv(src2 +
				13'(reg_wr_q.addr - TX_REG))));
		else if (reg_wr_q.we)
			chk(16'(reg_wr_q.data), 16'(m.memv(src +
				13'(reg_wr_q.addr - dst))));
		if (key_wr_q.we)
			chk(16'(key_wr_q.data), 16'(m.memv(kbase + 13'(key_wr_q.idx))));
		// a pushed byte is the one offered while valid, one edge earlier
		if (fifo_wr_q)
			chk(16'({rng_valid, fifo_wdata_q}), 16'(8'(rng_data - 8'h07)));
		if (nvm_ack && nvm_q.we) begin
			chk(16'(nvm_q.addr), 16'(kbase + 13'(nnvw)));
			chk(16'(nvm_q.wdata), 16'(8'ha0 + 8'(nnvw)));
			nnvw++;
		end
		nreg += int'(reg_wr_q.we === 1'b1);
		nkey += int'(key_wr_q.we === 1'b1);
		ndone += int'(done_q === 1'b1);
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task put(input logic [7:0] b);
		@(posedge mclk);
		m.fq.push_back(b);
	endtask : put

	task putn(input logic [31:0] w, input int n);
		@(posedge mclk);
		m.fq.delete();
		for (int i = 0; i < n; i++)
			put(w[31 - 8 * i -: 8]);
	endtask : putn

	task issue(input logic [7:0] c);
		@(posedge mclk);
		cmd_wr <= 1'b1;
		cmd_wdata <= c;
		@(posedge mclk);
		cmd_wr <= 1'b0;
		#1;
		chk(16'(cmd_q), 16'(c));
	endtask : issue

	task run(input logic [7:0] c, input logic ab);
		nreg = 0;
		nkey = 0;
		nnvw = 0;
		issue(c);
		for (int i = 0; i < 4000 && !(done_q | abort_q); i++) begin
			@(posedge mclk);
			#1;
		end
		chk(16'(abort_q), 16'(ab));
		chk(16'(done_q), 16'(!ab));
		@(posedge mclk);
		#1;
		chk(16'(cmd_q), 16'h0000);
	endtask : run

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reg_load;
		src = 13'h0080;
		dst = 8'h10;
		sc2 = 1'b0;
		putn(32'h80001005, 4);
		run(CMD_REG_LOAD, 1'b0);
		chk(16'(nreg), 16'h0005);
		putn(32'h800010ff, 3);
		run(CMD_REG_LOAD, 1'b1);
		chk(16'(m.fq.size()), 16'h0003);
		putn(32'h7f001002, 4);
		run(CMD_REG_LOAD, 1'b1);
		chk(16'(nreg), 16'h0000);
		putn(32'h00011002, 4);
		run(CMD_REG_LOAD, 1'b1);
		chk(16'(nreg), 16'h0000);
	endtask : t_reg_load

	task t_proto;
		dst = RX_REG;
		for (int k = 0; k < 6; k++) begin
			src = RX_BASE + 13'(rx_t[k]) * 13'h8;
			src2 = TX_BASE + 13'(tx_t[k]) * 13'h8;
			sc2 = 1'b1;
			putn({rx_t[k], tx_t[k], 16'h0000}, 2);
			run(CMD_PROTO, 1'b0);
			chk(16'(nreg), 16'h0010);
			chk(16'(rx_coding_q), 16'(rc_t[k]));
			chk(16'(tx_coding_q), 16'(tc_t[k]));
		end
		putn(32'h01120000, 2);
		run(CMD_PROTO, 1'b1);
		putn(32'h01000000, 1);
		run(CMD_PROTO, 1'b1);
		sc2 = 1'b0;
	endtask : t_proto

	task t_key;
		kbase = KEY_BASE + 13'h0012;
		putn(32'h03000000, 1);
		run(CMD_KEY_FETCH, 1'b0);
		chk(16'(nkey), 16'h0006);
		putn(32'h80000000, 1);
		run(CMD_KEY_FETCH, 1'b1);
		chk(16'(nkey), 16'h0000);
		putn(32'h0, 0);
		run(CMD_KEY_FETCH, 1'b1);
	endtask : t_key

	task t_store;
		kbase = KEY_BASE + 13'h02f4;
		putn(32'h7e000000, 1);
		for (int j = 0; j < 14; j++)
			put(8'ha0 + 8'(j));
		run(CMD_KEY_STORE, 1'b0);
		chk(16'(nnvw), 16'h000c);
		chk(16'(m.fq.size()), 16'h0002);
		chk(16'(m.fq[0]), 16'h00ac);
		putn(32'h80a0a1a2, 4);
		for (int j = 0; j < 3; j++)
			put(8'ha3 + 8'(j));
		run(CMD_KEY_STORE, 1'b1);
		chk(16'(nnvw), 16'h0000);
		putn(32'h00a0a1a2, 4);
		put(8'ha3);
		put(8'ha4);
		run(CMD_KEY_STORE, 1'b1);
		chk(16'(m.fq.size()), 16'h0006);
	endtask : t_store

	task t_random;
		putn(32'h0, 0);
		run(CMD_RANDOM, 1'b0);
		chk(16'(m.fq.size()), 16'h0040);
		chk(16'(m.ovf), 16'h0000);
	endtask : t_random

	task t_soft;
		m.lat = 2;
		src = DEF_BASE;
		dst = 8'h00;
		run(CMD_SOFT, 1'b0);
		chk(16'(nreg), 16'h0080);
		m.lat = 0;
	endtask : t_soft

	task t_kill;
		int n;
		ndone = 0;
		issue(CMD_SOFT);
		repeat (40) @(posedge mclk);
		issue(CMD_IDLE);
		repeat (6) @(posedge mclk);
		n = nreg;
		repeat (60) @(posedge mclk);
		#1;
		chk(16'(nreg), 16'(n));
		chk(16'(ndone), 16'h0000);
	endtask : t_kill

	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_reg_load;
		t_proto;
		t_key;
		t_store;
		t_random;
		t_soft;
		t_kill;
		end_of_test;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		errors++;
		end_of_test;
	end
endmodule : tb_top
